// *** rtl/udsb_top.sv ***
// Purpose: dma ready lines, sleep control, rx idle, break, baud generator
// Assumes: core fifo status arrives on ref_clk; rx and modem pins are async
// Notes: both dma ready outputs are active low
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps

// Notes on behaviour
// R1 - dma mode 0 or 1 chosen by fifo control bit 3
// R2 - mode 0 or fifos disabled gives single character transfers
// R3 - single mode: tx ready active while holding buffer empty
// R4 - single mode: rx ready active while any character held
// R5 - block mode: tx ready on trigger free space, off when full
// R6 - block mode: rx ready on trigger or timeout, off on empty/error
// R7 - sleep allowed only with enhanced bit 4 and int enable bit 4
// R8 - sleep only when rx idle, tx and rx empty, no other interrupt
// R9 - asleep: internal and baud clock enables stop
// R10 - wake on rx change, modem pin change or tx fifo write
// R11 - host must not write divisor while asleep
// R12 - rx idle after line high four word lengths plus twelve bits
// R13 - receive line sampled at the middle of each bit
// R14 - line control bit 6 forces transmit output low
// R15 - baud divisor is sixteen bits, valid one to 65535
// R16 - modem control bit 7 inserts divide by four prescaler
// R17 - prescaler divides by one after reset
// R18 - baud output is sixteen times the baud rate
// R19 - divisor equals clock over prescale over sixteen times baud
// R20 - divisor low byte bits 7..0, high byte bits 15..8
// R21 - zero divisor generates no baud clock
// R22 - one baud tick drives both transmitter and receiver
// R23 - reset leaves divisor bytes unchanged
// R24 - fifo error bit set while any rx entry is erroneous
// R25 - reset drives rx ready high and tx ready low
// R26 - both dma ready outputs are active low
module udsb_top
    import udsb_pkg::*;
#(
    parameter int DIV_W = 16
) (
    // clock, reset, enable
    input  wire logic          ref_clk,
    input  wire logic          rst,
    input  wire logic          clk_en,
    // register port
    input  wire logic [3:0]    reg_addr,
    input  wire logic [7:0]    reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [7:0]    reg_rdata,
    // core status and events
    input  wire udsb_core_st_t core_st,
    input  wire logic          tx_fifo_write,
    // serial pins
    input  wire logic          rx_pin,
    input  wire logic [3:0]    modem_pins,
    input  wire logic          tx_core,
    output logic               tx_pin,
    // dma requests, active low
    output logic               tx_dma_ready_n,
    output logic               rx_dma_ready_n,
    // clock enables to the core, and sleep status
    output logic               uart_clk_en,
    output logic               baud_tick,
    output logic               rx_sample,
    output logic               asleep
);

    typedef struct packed {
        logic [7:0]       div_lo;
        logic [7:0]       div_hi;
        logic [7:0]       fifo_ctrl;
        logic [7:0]       line_ctrl;
        logic [7:0]       modem_ctrl;
        logic [7:0]       int_enable;
        logic [7:0]       enh_feat;
        logic [5:0]       trigger;
        logic [3:0]       word_len;
        logic [7:0]       rdata;
        logic [1:0]       rx_sync;
        logic [1:0]       rx_seen;
        logic [7:0]       modem_s1;
        logic [3:0]       modem_seen;
        logic [1:0]       pre_cnt;
        logic [DIV_W-1:0] div_cnt;
        logic [3:0]       os_cnt;
        logic [6:0]       idle_bits;
        logic             rx_idle;
        logic             tx_rdy;
        logic             rx_rdy;
        logic             txd;
        udsb_pwr_t        pwr;
    } udsb_state_t;

    udsb_state_t st, next_st;

    logic [DIV_W-1:0] divisor;
    logic             pre_tick;
    logic             tick;
    logic             single_mode;
    logic             sleep_ok;
    logic             wake;
    logic [6:0]       idle_limit;
    logic             rx_now;
    logic [3:0]       modem_now;

    assign divisor     = {st.div_hi, st.div_lo}; // R20 R15
    assign single_mode = !st.fifo_ctrl[FCR_DMA_MODE]
                       || !st.fifo_ctrl[FCR_FIFO_EN]; // R1 R2
    assign rx_now      = st.rx_sync[1];
    assign modem_now   = st.modem_s1[7:4];
    assign idle_limit  = 7'(IDLE_MULT * st.word_len + IDLE_EXTRA); // R12

    // prescaler stage ahead of the divisor
    assign pre_tick = st.modem_ctrl[MCR_PRESCALE]
                    ? (st.pre_cnt == 2'(PRESCALE_DIV - 1)) : 1'b1; // R16
    assign tick = (st.pwr == UDSB_AWAKE) && clk_en && pre_tick
                && (divisor != '0) && (st.div_cnt == DIV_W'(1)); // R21

    assign sleep_ok = st.enh_feat[EFR_ENHANCED]
                    && st.int_enable[IER_SLEEP]; // R7
    assign wake = (rx_now != st.rx_seen[0])
                || (modem_now != st.modem_seen)
                || tx_fifo_write; // R10

    function automatic logic [7:0] read_mux(input logic [3:0] a,
                                            input udsb_state_t s);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            ADDR_DIV_LOW:    d = s.div_lo;
            ADDR_DIV_HIGH:   d = s.div_hi;
            ADDR_FIFO_CTRL:  d = s.fifo_ctrl;
            ADDR_LINE_CTRL:  d = s.line_ctrl;
            ADDR_MODEM_CTRL: d = s.modem_ctrl;
            ADDR_INT_ENABLE: d = s.int_enable;
            ADDR_ENH_FEAT:   d = s.enh_feat;
            ADDR_TRIGGER:    d = {2'b00, s.trigger};
            ADDR_WORD_LEN:   d = {4'h0, s.word_len};
            ADDR_STATUS: begin
                d[ST_ASLEEP]   = (s.pwr == UDSB_ASLEEP);
                d[ST_RX_IDLE]  = s.rx_idle;
                d[ST_TX_READY] = s.tx_rdy;
                d[ST_RX_READY] = s.rx_rdy;
                d[ST_FIFO_ERR] = core_st.rx_entry_err; // R24
            end
            default:         d = 8'h00;
        endcase
        return d;
    endfunction

    always_comb begin
        next_st = st;
        if (clk_en) begin
            // pin synchronisers run whenever clk_en is high, awake or asleep, so wake can be seen
            next_st.rx_sync  = {st.rx_sync[0], rx_pin};
            next_st.modem_s1 = {st.modem_s1[3:0], modem_pins};
            next_st.rdata    = reg_rd ? read_mux(reg_addr, st) : st.rdata;

            if (reg_wr) begin
                unique case (reg_addr)
                    ADDR_DIV_LOW:    next_st.div_lo = reg_wdata; // R20
                    ADDR_DIV_HIGH:   next_st.div_hi = reg_wdata; // R20
                    ADDR_FIFO_CTRL:  next_st.fifo_ctrl = reg_wdata;
                    ADDR_LINE_CTRL:  next_st.line_ctrl = reg_wdata;
                    ADDR_MODEM_CTRL: next_st.modem_ctrl = reg_wdata;
                    ADDR_INT_ENABLE: next_st.int_enable = reg_wdata;
                    ADDR_ENH_FEAT:   next_st.enh_feat = reg_wdata;
                    ADDR_TRIGGER:    next_st.trigger = reg_wdata[5:0];
                    ADDR_WORD_LEN:   next_st.word_len = reg_wdata[3:0];
                    default:         next_st.rdata = st.rdata;
                endcase
            end

            unique case (st.pwr)
                UDSB_AWAKE: begin
                    // baud generator, stopped in sleep
                    next_st.pre_cnt = st.modem_ctrl[MCR_PRESCALE]
                                    ? st.pre_cnt + 2'd1 : 2'd0;
                    if (divisor == '0) begin
                        next_st.div_cnt = '0; // R21
                    end else if (pre_tick) begin
                        next_st.div_cnt = (st.div_cnt <= DIV_W'(1))
                                        ? divisor : st.div_cnt - DIV_W'(1);
                    end
                    if (tick) begin
                        next_st.os_cnt = st.os_cnt + 4'd1; // R18
                    end
                    // idle counting on mid-bit samples
                    if (tick && st.os_cnt == 4'd7) begin // R13
                        if (!rx_now) begin
                            next_st.idle_bits = '0;
                            next_st.rx_idle   = 1'b0;
                        end else if (st.idle_bits >= idle_limit - 7'd1) begin
                            next_st.rx_idle = 1'b1; // R12
                        end else begin
                            next_st.idle_bits = st.idle_bits + 7'd1;
                        end
                    end
                    // track pins while awake so sleep compares to entry
                    next_st.rx_seen    = {1'b0, rx_now};
                    next_st.modem_seen = modem_now;
                    if (sleep_ok && st.rx_idle && core_st.tx_hold_empty
                        && core_st.tx_shift_empty
                        && core_st.rx_count == '0
                        && !core_st.other_int_pending && !wake) begin
                        next_st.pwr = UDSB_ASLEEP; // R8
                    end
                end
                UDSB_ASLEEP: begin
                    if (wake || !sleep_ok) begin
                        next_st.pwr = UDSB_AWAKE; // R10
                    end
                end
            endcase

            // dma ready levels, held high-true internally
            if (single_mode) begin
                next_st.tx_rdy = core_st.tx_hold_empty; // R3
                next_st.rx_rdy = core_st.rx_count != '0; // R4
            end else begin
                if (core_st.tx_full) begin
                    next_st.tx_rdy = 1'b0; // R5
                end else if (core_st.tx_free >= {1'b0, st.trigger}) begin
                    next_st.tx_rdy = 1'b1; // R5
                end
                if (core_st.rx_count == '0 || core_st.rx_entry_err) begin
                    next_st.rx_rdy = 1'b0; // R6 R24
                end else if (core_st.rx_trigger_hit || core_st.rx_timeout) begin
                    next_st.rx_rdy = 1'b1; // R6
                end
            end

            next_st.txd = st.line_ctrl[LCR_BREAK] ? 1'b0 : tx_core; // R14
        end

        if (rst) begin
            // divisor bytes survive reset
            next_st            = '0;
            next_st.div_lo     = st.div_lo; // R23
            next_st.div_hi     = st.div_hi; // R23
            next_st.line_ctrl  = RST_LINE_CTRL;
            next_st.modem_ctrl = RST_ZERO; // R17
            next_st.fifo_ctrl  = RST_ZERO;
            next_st.int_enable = RST_ZERO;
            next_st.enh_feat   = RST_ZERO;
            next_st.word_len   = RST_WORD_LEN;
            next_st.trigger    = RST_TRIGGER;
            next_st.rx_sync    = 2'b11;
            next_st.txd        = 1'b1;
            next_st.tx_rdy     = 1'b1; // R25
            next_st.rx_rdy     = 1'b0; // R25
            next_st.pwr        = UDSB_AWAKE;
        end
    end

    always_ff @(posedge ref_clk) begin
        st <= next_st;
    end

    assign reg_rdata      = st.rdata;
    assign tx_pin         = st.txd;
    assign tx_dma_ready_n = !st.tx_rdy; // R26
    assign rx_dma_ready_n = !st.rx_rdy; // R26
    assign asleep         = st.pwr == UDSB_ASLEEP;
    assign uart_clk_en    = clk_en && !asleep; // R9
    assign baud_tick      = tick; // R22 R9 R19
    assign rx_sample      = tick && st.os_cnt == 4'd7; // R13

endmodule

// *** rtl/udsb_pkg.sv ***
// Purpose: shared constants and types for the uart dma/sleep/baud support
// Assumes: byte-wide register port, 10 MHz ref_clk
// Notes: offsets are register indices on the plain register port
package udsb_pkg;

    // register map
    localparam logic [3:0] ADDR_DIV_LOW   = 4'h0;
    localparam logic [3:0] ADDR_DIV_HIGH  = 4'h1;
    localparam logic [3:0] ADDR_FIFO_CTRL = 4'h2;
    localparam logic [3:0] ADDR_LINE_CTRL = 4'h3;
    localparam logic [3:0] ADDR_MODEM_CTRL = 4'h4;
    localparam logic [3:0] ADDR_INT_ENABLE = 4'h5;
    localparam logic [3:0] ADDR_ENH_FEAT  = 4'h6;
    localparam logic [3:0] ADDR_STATUS    = 4'h7;
    localparam logic [3:0] ADDR_TRIGGER   = 4'h8;
    localparam logic [3:0] ADDR_WORD_LEN  = 4'h9;

    // field positions
    localparam int FCR_FIFO_EN  = 0;
    localparam int FCR_DMA_MODE = 3;
    localparam int LCR_BREAK    = 6;
    localparam int MCR_PRESCALE = 7;
    localparam int IER_SLEEP    = 4;
    localparam int EFR_ENHANCED = 4;
    localparam int ST_ASLEEP    = 0;
    localparam int ST_RX_IDLE   = 1;
    localparam int ST_TX_READY  = 2;
    localparam int ST_RX_READY  = 3;
    localparam int ST_FIFO_ERR  = 7;

    // reset values
    localparam logic [7:0] RST_ZERO      = 8'h00;
    localparam logic [7:0] RST_LINE_CTRL = 8'h1D;
    localparam logic [3:0] RST_WORD_LEN  = 4'h8;
    localparam logic [5:0] RST_TRIGGER   = 6'h01;

    // timing
    localparam int PRESCALE_DIV  = 4;
    localparam int OVERSAMPLE    = 16;
    localparam int IDLE_MULT     = 4;
    localparam int IDLE_EXTRA    = 12;
    localparam int CLK_PERIOD_NS = 100;

    // status from the fifo/receiver core
    typedef struct packed {
        logic       tx_hold_empty;
        logic       tx_shift_empty;
        logic [6:0] tx_free;
        logic       tx_full;
        logic [6:0] rx_count;
        logic       rx_trigger_hit;
        logic       rx_timeout;
        logic       rx_entry_err;
        logic       other_int_pending;
    } udsb_core_st_t;

    typedef enum logic [1:0] {
        UDSB_AWAKE,
        UDSB_ASLEEP
    } udsb_pwr_t;

endpackage

// *** verification/udsb_asserts.sv ***
// Purpose: port-level checks for udsb_top
// Assumes: register writes on the port are mirrored here
// Notes: divisor mirror is not cleared by reset, as in the device
`timescale 1ns/1ps
module udsb_asserts
    import udsb_pkg::*;
(
    // clock and reset
    input wire logic          ref_clk,
    input wire logic          rst,
    input wire logic          clk_en,
    // register port
    input wire logic [3:0]    reg_addr,
    input wire logic [7:0]    reg_wdata,
    input wire logic          reg_wr,
    // core side
    input wire udsb_core_st_t core_st,
    input wire logic          tx_fifo_write,
    // watched outputs
    input wire logic          tx_pin,
    input wire logic          tx_dma_ready_n,
    input wire logic          rx_dma_ready_n,
    input wire logic          uart_clk_en,
    input wire logic          baud_tick,
    input wire logic          asleep
);
    logic [7:0] fifo_control_reg, line_control_reg, modem_control_reg, interrupt_enable_reg, enhanced_feature_reg, dlo, dhi;
    logic       run;
    wire logic  single = !fifo_control_reg[FCR_FIFO_EN] || !fifo_control_reg[FCR_DMA_MODE];
    wire logic  may_sleep = interrupt_enable_reg[IER_SLEEP] && enhanced_feature_reg[EFR_ENHANCED]
        && core_st.tx_hold_empty && core_st.tx_shift_empty
        && core_st.rx_count == 7'h00 && !core_st.other_int_pending;
    wire logic  slow8 = {dhi, dlo} == 16'h0002 && modem_control_reg[MCR_PRESCALE]
        && clk_en && !asleep;

    // run: previous cycle was a live, non-reset clock
    always_ff @(posedge ref_clk) begin
        run <= !rst && clk_en;
        if (rst) begin
            {fifo_control_reg, modem_control_reg, interrupt_enable_reg, enhanced_feature_reg} <= '0;
            line_control_reg <= RST_LINE_CTRL;
        end else if (clk_en && reg_wr) begin
            case (reg_addr)
                ADDR_DIV_LOW:    dlo <= reg_wdata;
                ADDR_DIV_HIGH:   dhi <= reg_wdata;
                ADDR_FIFO_CTRL:  fifo_control_reg <= reg_wdata;
                ADDR_LINE_CTRL:  line_control_reg <= reg_wdata;
                ADDR_MODEM_CTRL: modem_control_reg <= reg_wdata;
                ADDR_INT_ENABLE: interrupt_enable_reg <= reg_wdata;
                ADDR_ENH_FEAT:   enhanced_feature_reg <= reg_wdata;
                default: ;
            endcase
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_gap8;
        baud_tick && slow8 ##1 (!baud_tick && slow8) [*7] ##1 baud_tick;
    endsequence

    a_reset_levels:
    assert property ($past(rst) |-> !tx_dma_ready_n && rx_dma_ready_n
        && tx_pin && !asleep) else $error("reset levels wrong");
    a_sleep_stops_clk:
    assert property (asleep |-> !uart_clk_en && !baud_tick)
        else $error("clock runs while asleep");
    a_sleep_entry_ok:
    assert property ($rose(asleep) |-> $past(may_sleep))
        else $error("sleep entered without its conditions");
    a_wake_on_write:
    assert property (asleep && tx_fifo_write |-> ##[1:2] !asleep)
        else $error("no wake after tx write");
    a_single_tx_ready:
    assert property (run && $past(single) |->
        tx_dma_ready_n == !$past(core_st.tx_hold_empty))
        else $error("single tx ready wrong");
    a_single_rx_ready:
    assert property (run && $past(single) |->
        rx_dma_ready_n == ($past(core_st.rx_count) == 7'h00))
        else $error("single rx ready wrong");
    a_block_tx_full:
    assert property (run && !$past(single) && $past(core_st.tx_full)
        |-> tx_dma_ready_n) else $error("tx ready while full");
    a_block_rx_off:
    assert property (run && !$past(single) && ($past(core_st.rx_count)
        == 7'h00 || $past(core_st.rx_entry_err)) |-> rx_dma_ready_n)
        else $error("rx ready while empty or in error");
    a_break_low:
    assert property (line_control_reg[LCR_BREAK] && $past(line_control_reg[LCR_BREAK]) |-> !tx_pin)
        else $error("break does not hold line low");
    a_prescale_gap:
    assert property (s_gap8 |-> ##1 (!baud_tick || !slow8) [*7]
        ##1 (baud_tick || !slow8)) else $error("prescaled period wrong");
    a_zero_div_idle:
    assert property (dlo == 8'h00 && dhi == 8'h00 && $past(dlo) == 8'h00
        && $past(dhi) == 8'h00 |-> !baud_tick)
        else $error("tick with zero divisor");
endmodule

bind udsb_top udsb_asserts u_asserts (
    .ref_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .core_st,
    .tx_fifo_write, .tx_pin, .tx_dma_ready_n, .rx_dma_ready_n,
    .uart_clk_en, .baud_tick, .asleep
);

// *** verification/udsb_dma_model.sv ***
// Purpose: dma controller stand-in serving the transmit request
// Assumes: request is active low, sampled on ref_clk
// Notes: GAP sets how slowly it serves; en switches it off
`timescale 1ns/1ps
module udsb_dma_model #(
    parameter int GAP = 3
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // control and request
    input  wire logic en,
    input  wire logic tx_dma_ready_n,
    // transfer strobe
    output logic      tx_fifo_write
);
    int wait_cnt;

    always_ff @(posedge ref_clk) begin
        if (rst || !en) begin
            tx_fifo_write <= 1'b0;
            wait_cnt      <= GAP;
        end else if (wait_cnt > 0) begin
            tx_fifo_write <= 1'b0;
            wait_cnt      <= wait_cnt - 1;
        end else begin
            // one character per request, then back off
            tx_fifo_write <= !tx_dma_ready_n;
            wait_cnt      <= GAP;
        end
    end
endmodule

// *** verification/test_udsb_top.sv ***
// Purpose: self-checking bench for udsb_top
// Assumes: 10 MHz ref_clk, sync active-high reset
// Notes: divisors kept small so baud periods stay short
`timescale 1ns/1ps
module test_udsb_top
    import udsb_pkg::*;
();
    typedef struct packed {
        logic [7:0]    fifo_control_reg;
        udsb_core_st_t st;
        logic [1:0]    exp_n;
    } udsb_row_t;
    localparam udsb_core_st_t IDLE = {2'h3, 7'h40, 1'h0, 7'h00, 4'h0};
    localparam int            BIT  = 2 * OVERSAMPLE;

    logic          ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1;
    logic [3:0]    reg_addr = 4'h0, modem_pins = 4'h0;
    logic [7:0]    reg_wdata = 8'h00, rd_val, reg_rdata;
    logic          reg_wr = 1'b0, reg_rd = 1'b0, tx_fifo_write;
    logic          rx_pin = 1'b1, tx_core = 1'b1, dma_en = 1'b0;
    logic          tx_pin, tx_dma_ready_n, rx_dma_ready_n;
    logic          uart_clk_en, baud_tick, asleep, rx_sample;
    udsb_core_st_t core_st = IDLE;
    int            fails = 0, samples_checked = 0, per;
    wire logic [1:0] dma_n = {tx_dma_ready_n, rx_dma_ready_n};
    wire logic [3:0] rst_outs = {dma_n, tx_pin, asleep};
    // rows: fcr, core status {hold,shift,free,full,count,hit,tmo,err,int}
    udsb_row_t rows [9] = '{
        '{8'h00, {2'h3, 7'h40, 1'h0, 7'h00, 4'h0}, 2'h1},
        '{8'h00, {2'h1, 7'h3F, 1'h0, 7'h03, 4'h0}, 2'h2},
        '{8'h01, {2'h1, 7'h3F, 1'h0, 7'h01, 4'h0}, 2'h2},
        '{8'h09, {2'h1, 7'h08, 1'h0, 7'h02, 4'h0}, 2'h0},
        '{8'h09, {2'h1, 7'h00, 1'h1, 7'h02, 4'h8}, 2'h2},
        '{8'h09, {2'h1, 7'h04, 1'h0, 7'h02, 4'h0}, 2'h2},
        '{8'h09, {2'h1, 7'h04, 1'h0, 7'h02, 4'h2}, 2'h3},
        '{8'h09, {2'h1, 7'h08, 1'h0, 7'h01, 4'h4}, 2'h0},
        '{8'h08, {2'h1, 7'h40, 1'h0, 7'h01, 4'h0}, 2'h2}};
    // bit 16 selects the prescaler
    logic [16:0] bauds [4] = '{17'h00100, 17'h00003, 17'h00001, 17'h10002};

    udsb_top dut (
        .ref_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .core_st, .tx_fifo_write, .rx_pin, .modem_pins,
        .tx_core, .tx_pin, .tx_dma_ready_n, .rx_dma_ready_n,
        .uart_clk_en, .baud_tick, .rx_sample, .asleep
    );
    udsb_dma_model #(.GAP(3)) dma (
        .ref_clk, .rst, .en(dma_en), .tx_dma_ready_n, .tx_fifo_write
    );

    always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

    task automatic check(input string what, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    task automatic do_reset(input int n);
        rst <= 1'b1;
        repeat (n) @(posedge ref_clk);
        rst <= 1'b0;
        #1 check("reset outputs", rst_outs, 4'h6);
    endtask
    // second count is a whole tick-to-tick period
    task automatic meas(output int n);
        repeat (2) begin
            n = 0;
            do begin
                @(posedge ref_clk);
                #1 n++;
            end while (!baud_tick && n < 2000);
        end
    endtask
    task automatic wait_sleep(input logic want);
        for (int i = 0; i < 20 && asleep !== want; i++) begin
            @(posedge ref_clk);
            #1;
        end
        check("asleep", asleep, want);
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        $display("watchdog expired");
        end_sim();
    end

    initial begin
        do_reset(20);
        // divisor bytes power up unknown; clear them so the counter settles
        wr(ADDR_DIV_LOW, 8'h00);
        wr(ADDR_DIV_HIGH, 8'h00);
        rd(ADDR_LINE_CTRL);
        check("line ctrl", rd_val, RST_LINE_CTRL);
        rd(4'hF);
        check("unmapped", rd_val, 8'h00);
        wr(ADDR_TRIGGER, 8'h08);
        foreach (rows[i]) begin
            wr(ADDR_FIFO_CTRL, rows[i].fifo_control_reg);
            core_st <= rows[i].st;
            repeat (2) @(posedge ref_clk);
            #1 check("dma", dma_n, rows[i].exp_n);
        end
        $display("test dma rows done");
        foreach (bauds[i]) begin
            wr(ADDR_MODEM_CTRL, {bauds[i][16], 7'h00});
            wr(ADDR_DIV_LOW, bauds[i][7:0]);
            wr(ADDR_DIV_HIGH, bauds[i][15:8]);
            meas(per);
            check("period", per[15:0], 16'(bauds[i][15:0] *
                (bauds[i][16] ? PRESCALE_DIV : 1)));
        end
        do_reset(2);
        rd(ADDR_DIV_LOW);
        check("div low kept", rd_val, 8'h02);
        meas(per);
        check("period after reset", per[15:0], 16'h0002);
        // one mid-bit sample per sixteen ticks
        per = 0;
        repeat (10 * BIT) begin
            @(posedge ref_clk);
            #1 per += rx_sample;
        end
        check("mid-bit samples", per[15:0], 16'h000A);
        $display("test baud done");
        core_st <= IDLE;
        rx_pin  <= 1'b0;
        repeat (2 * BIT) @(posedge ref_clk);
        rx_pin  <= 1'b1;
        repeat ((IDLE_MULT * RST_WORD_LEN + IDLE_EXTRA - 2) * BIT)
            @(posedge ref_clk);
        rd(ADDR_STATUS);
        check("rx idle early", rd_val[ST_RX_IDLE], 1'h0);
        repeat (4 * BIT) @(posedge ref_clk);
        rd(ADDR_STATUS);
        check("rx idle", rd_val[ST_RX_IDLE], 1'h1);
        $display("test rx idle done");
        wr(ADDR_INT_ENABLE, 8'h10);
        repeat (10) @(posedge ref_clk);
        #1 check("asleep", asleep, 1'h0);
        wr(ADDR_ENH_FEAT, 8'h10);
        wait_sleep(1'h1);
        check("clocks", {uart_clk_en, baud_tick}, 2'h0);
        dma_en <= 1'b1;
        wait_sleep(1'h0);
        dma_en <= 1'b0;
        wait_sleep(1'h1);
        modem_pins <= 4'h4;
        wait_sleep(1'h0);
        $display("test sleep done");
        wr(ADDR_INT_ENABLE, 8'h00);
        wr(ADDR_LINE_CTRL, RST_LINE_CTRL | 8'h40);
        repeat (2) @(posedge ref_clk);
        #1 check("break", tx_pin, 1'h0);
        wr(ADDR_LINE_CTRL, RST_LINE_CTRL);
        repeat (2) @(posedge ref_clk);
        #1 check("no break", tx_pin, tx_core);
        // clock enable low freezes ticks, clocks and register writes
        @(posedge ref_clk);
        clk_en <= 1'b0;
        wr(ADDR_LINE_CTRL, RST_LINE_CTRL | 8'h40);
        per = 0;
        repeat (20) begin
            @(posedge ref_clk);
            #1 per += baud_tick + uart_clk_en;
        end
        check("frozen", {per[14:0], tx_pin}, 16'h0001);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 check("write ignored", tx_pin, 1'h1);
        $display("test clock enable done");
        wr(ADDR_DIV_LOW, 8'h00);
        wr(ADDR_DIV_HIGH, 8'h00);
        per = 0;
        repeat (100) begin
            @(posedge ref_clk);
            #1 per += baud_tick;
        end
        check("ticks", per[15:0], 16'h0000);
        $display("test break and zero divisor done");
        end_sim();
    end
endmodule
